// file: bench/ccrb_bank_test.sv
/*
  Self-checking bench for the register bank with a reference model of its registers.
  Assumes the I2C host model in this folder and a shortened second.
*/
`timescale 1ns/1ps
module ccrb_bank_test;
  import ccrb_pkg::*;
  localparam int SEC = 200;
  localparam logic [6:0] DEV = 7'h10;
  localparam logic [7:0] RA [8] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h20};
  localparam logic [15:0] CT [7] = '{16'h1303, 16'h1200, 16'h1300, 16'h1210, 16'h1214,
                                     16'h1303, 16'h1224};
  logic clock_i, rst_i, scl, pull, adapter, pin_n, dynamic_power_management, pin_en, sda_o, sda_oe, tick, wexp;
  logic [7:0] pin_set, thr, a, d;
  logic act;
  wire sda_w = ~(pull | sda_oe);
  ccrb_cfg_s cfg;
  int err_total, n_compared, n_exp, m_code, m_pre, m_tmr, m_cv, m_chg, acks;

  ccrb_bank #(.DEV_ADDR(DEV), .SEC_CYCLES(SEC)) u_ccrb_bank (.clock_i(clock_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .adapter_present_i(adapter),
    .charge_pin_n_i(pin_n), .dynamic_power_management_i(dynamic_power_management), .charge_pin_function_en_i(pin_en),
    .charge_current_pin_setting_i(pin_set), .cfg_o(cfg), .termination_current_threshold_o(thr),
    .charging_active_o(act), .safety_tick_o(tick), .watchdog_expired_o(wexp));
  ccrb_i2c_host u_ccrb_i2c_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl),
    .sda_pull_o(pull));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    if (wexp === 1'b1) n_exp++;
  end

  task automatic chk_reg(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic int clamp(input int c);
    return c < 5 ? 5 : (c > 200 ? 200 : c);
  endfunction
  task automatic mreset();
    m_code = 8'h28;
    m_pre = 8'h0f;
    m_tmr = 8'h1d;
    m_cv = 0;
    m_chg = 8'hc9;
  endtask
  task automatic mwr(input logic [7:0] ad, dd);
    case (ad)
      8'h12: m_code = clamp({m_code[7:6], dd[7:2]});
      8'h13: m_code = clamp({dd[1:0], m_code[5:0]});
      8'h14: m_pre = dd & 8'h0f;
      8'h15: m_tmr = dd;
      8'h16: m_cv = dd & 8'h0f;
      8'h17: m_chg = dd & 8'hdf;
      8'h19: if (dd[7]) mreset();
      default: ;
    endcase
  endtask
  function automatic logic [7:0] mrd(input logic [7:0] ad);
    case (ad)
      8'h12: return 8'(m_code << 2);
      8'h13: return 8'(m_code >> 6);
      8'h14: return 8'(m_pre);
      8'h15: return 8'(m_tmr);
      8'h16: return 8'(m_cv);
      8'h17: return 8'(m_chg);
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk_all();
    repeat (6) @(negedge clock_i);
    chk_out(cfg, {m_pre[3:0], m_tmr[7:0], m_cv[3:0], m_chg[7:6], m_chg[2:0]});
    chk_out(thr, (pin_en && pin_set < m_code) ? pin_set : m_code);
    chk_out(act, m_chg[0] && (m_chg[4] || !pin_n));
    chk_out(sda_o, 1'b0);
  endtask
  task automatic wr(input logic [7:0] ad, dd);
    u_ccrb_i2c_host.write(DEV, ad, dd, acks);
    mwr(ad, dd);
    chk_reg(8'(acks), 8'd3);
    chk_all();
  endtask
  task automatic rd(input logic [7:0] ad);
    logic [7:0] q;
    u_ccrb_i2c_host.read(DEV, ad, q, acks);
    chk_reg(q, mrd(ad));
    chk_reg(8'(acks), 8'd3);
  endtask
  task automatic tick_gap();
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 3 * SEC) begin
      @(negedge clock_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (tick !== 1'b1 && n < 3 * SEC);
    chk_out(n, (m_tmr[0] && dynamic_power_management) ? 2 * SEC : SEC);
  endtask

  initial begin
    repeat (90000) @(posedge clock_i);
    err_total++;
    finish_test();
  end
  initial begin
    {rst_i, adapter, pin_n, dynamic_power_management, pin_en, pin_set} = {1'b1, 12'h000};
    mreset();
    void'($urandom(32'hb395));
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    chk_all();
    foreach (RA[i]) rd(RA[i]);
    wr(8'h15, 8'h0d);
    u_ccrb_i2c_host.write(7'h11, 8'h17, 8'h00, acks);
    chk_reg(8'(acks), 8'd0);
    foreach (CT[i]) begin
      wr(CT[i][15:8], CT[i][7:0]);
      rd(8'h12);
      rd(8'h13);
    end
    for (int i = 0; i < 10; i++) begin
      a = 8'h12 + 8'($urandom % 6);
      d = 8'($urandom);
      if (a == 8'h15) d[5:4] = 2'b00;
      {pin_n, dynamic_power_management, pin_en} = 3'($urandom);
      pin_set = 8'($urandom % 256);
      wr(a, d);
      rd(a);
      tick_gap();
    end
    wr(8'h17, 8'hcd);
    adapter = 1'b1;
    m_chg = m_chg & 8'hfb;
    chk_all();
    wr(8'h16, 8'h07);
    wr(8'h15, 8'h15);
    // The host restarts before the period ends to keep its settings
    wr(8'h17, 8'h3e);
    rd(8'h17);
    repeat (30 * SEC) @(negedge clock_i);
    wr(8'h17, 8'h3e);
    repeat (38 * SEC) @(negedge clock_i);
    chk_out(n_exp, 0);
    repeat (3 * SEC) @(negedge clock_i);
    chk_out(n_exp, 1);
    m_tmr = m_tmr | 8;
    m_cv = 0;
    m_chg = {m_chg[7:3], 2'b00, m_chg[3]};
    chk_all();
    // Longer watchdog period, charge enable falls to zero on expiry
    wr(8'h15, 8'h2d);
    wr(8'h17, 8'h37);
    repeat (78 * SEC) @(negedge clock_i);
    chk_out(n_exp, 1);
    repeat (3 * SEC) @(negedge clock_i);
    chk_out(n_exp, 2);
    m_chg = {m_chg[7:3], 2'b00, m_chg[3]};
    chk_all();
    wr(8'h19, 8'h80);
    foreach (RA[i]) rd(RA[i]);
    finish_test();
  end
endmodule

// file: bench/ccrb_i2c_host.sv
/*
  Behavioural I2C host that drives the register bank's serial pins.
  Assumes an open-drain SDA wire resolved by the bench; SCL stands high between frames.
*/
`timescale 1ns/1ps
module ccrb_i2c_host (
  // Clock and resolved wire
  input wire logic clock_i,
  input wire logic sda_i,
  // Host lines
  output logic scl_o,
  output logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // SDA moves only while SCL is low, so no false START or STOP
  task automatic clk_bit(input logic b, output logic s);
    sda_pull_o = ~b;
    wt(6);
    scl_o = 1'b1;
    wt(3);
    s = sda_i;
    wt(3);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
      q[i] = s;
    end
    clk_bit(ack_in, s);
    ack = ~s;
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    sda_pull_o = 1'b1;
    wt(4);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    sda_pull_o = 1'b0;
    wt(4);
  endtask
  task automatic write(input logic [6:0] dev, input logic [7:0] p, d, output int acks);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(p, 1'b1, q, a1);
    byte_io(d, 1'b1, q, a2);
    stop();
    acks = a0 + a1 + a2;
  endtask
  // One byte per read; the host NACKs it to end the transfer
  task automatic read(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] q,
                      output int acks);
    logic a0, a1, a2, x;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(p, 1'b1, q, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, q, a2);
    byte_io(8'hff, 1'b1, q, x);
    stop();
    acks = a0 + a1 + a2;
  endtask
endmodule

// file: inc/ccrb_pkg.sv
/*
  Constants, register map and types for the charge control register bank.
  Assumes one 50 MHz clock and an I2C host reaching the bank through the device pins.
*/
// How it works
// - Termination register is 16 bits; low byte at 0x12, high byte at 0x13.
// - Termination code in bits 9:2, 50 mA steps, clamped 05h..C8h, resets to 28h.
// - Effective termination is the lower of code and pin setting when pin enabled.
// - Bit 3 enables termination, bit 0 enables pre-charge; both set at reset.
// - Two-bit fast-charge entry threshold, 30/55/66.7/71.4 percent, resets to 11.
// - Timer bits 7:6 choose top-off timer: off, 15, 30, 45 minutes.
// - Timer bits 5:4 choose watchdog: off, 40, 80, 160 s; resets to 01.
// - Timer bit 3 enables safety timer; set at reset and on watchdog expiry.
// - Timer bits 2:1 choose safety time 5, 8, 12, 24 hours; resets to 10.
// - Timer bit 0 makes safety timer count at half rate during input DYNAMIC_POWER_MANAGEMENT.
// - Four-bit constant-voltage timer; zero disables, n selects n hours.
// - Charger bits 7:6 choose recharge threshold 93.0..97.6 percent; reset 11.
// - Writing one to restart bit restarts watchdog; bit then clears itself.
// - Charger bit 4 set makes the charge-enable pin ignored.
// - On expiry the charge enable bit loads the value of charger bit 3.
// - Bit 2 selects high impedance; cleared by reset, expiry, adapter plug-in.
// - Bit 1 sinks battery sense node to ground; host should stop current conversion.
// - Expiry restores load, high impedance, safety enable, CV timer; charge enable takes bit 3.
// - Charger bit 0 enables charging; charger register resets to C9h.
// - Writing one to the register reset bit restores all registers; bit clears.
package ccrb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam longint unsigned NS_PER_S = 64'd1_000_000_000;
  localparam int unsigned SEC_CYCLES = int'(NS_PER_S / CLK_PERIOD_NS);
  // Watchdog periods in seconds
  localparam logic [7:0] WD_PERIOD_1_S = 8'd40;
  localparam logic [7:0] WD_PERIOD_2_S = 8'd80;
  localparam logic [7:0] WD_PERIOD_3_S = 8'd160;
  // Byte addresses on the serial bus
  localparam logic [7:0] OFS_TERM_LO = 8'h12;
  localparam logic [7:0] OFS_TERM_HI = 8'h13;
  localparam logic [7:0] OFS_PRECHARGE_PHASE = 8'h14;
  localparam logic [7:0] OFS_TIMER = 8'h15;
  localparam logic [7:0] OFS_CV = 8'h16;
  localparam logic [7:0] OFS_CHG = 8'h17;
  localparam logic [7:0] OFS_PATH = 8'h19;
  // Reset values, termination clamp limits and write mask
  localparam logic [7:0] RST_TERM_CODE = 8'h28;
  localparam logic [7:0] RST_PRECHARGE_PHASE = 8'h0f;
  localparam logic [7:0] RST_TIMER = 8'h1d;
  localparam logic [7:0] RST_CV = 8'h00;
  localparam logic [7:0] RST_CHG = 8'hc9;
  localparam logic [7:0] TERM_CODE_MIN = 8'h05;
  localparam logic [7:0] TERM_CODE_MAX = 8'hc8;
  localparam logic [7:0] WMASK_LOW4 = 8'h0f;
  // Field positions
  localparam int PATH_REG_RESET_BIT = 7;
  localparam int CHG_RESTART_BIT = 5;
  localparam int CHG_PIN_IGNORE_BIT = 4;
  localparam int CHG_EXPIRY_VAL_BIT = 3;
  localparam int CHG_HIZ_BIT = 2;
  localparam int CHG_LOAD_BIT = 1;
  localparam int CHG_ENABLE_BIT = 0;
  localparam int TMR_SAFETY_EN_BIT = 3;
  localparam int TMR_HALF_RATE_BIT = 0;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK
  } ccrb_i2c_e;

  typedef struct packed {
    logic [7:0] term_code;
    logic [7:0] precharge_phase;
    logic [7:0] timer;
    logic [7:0] cv;
    logic [7:0] chg;
  } ccrb_regs_s;

  typedef struct packed {
    logic termination_enable;
    logic [1:0] fastcharge_entry_threshold;
    logic precharge_enable;
    logic [1:0] topoff_timer_select;
    logic [1:0] watchdog_select;
    logic safety_timer_enable;
    logic [1:0] safety_timer_select;
    logic safety_timer_half_rate;
    logic [3:0] constant_voltage_timer;
    logic [1:0] auto_recharge_threshold;
    logic high_impedance_enable;
    logic battery_load_enable;
    logic charging_enable;
  } ccrb_cfg_s;
endpackage

// file: verilog/ccrb_bank.sv
/*
  Charge control register bank behind an I2C target port, with the host watchdog.
  Assumes the host is the only I2C controller; scl and sda arrive unsynchronised,
  the adapter and charge-enable pins likewise; DYNAMIC_POWER_MANAGEMENT and pin-setting inputs are on clock_i.
*/
`timescale 1ns/1ps
module ccrb_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h10,
  parameter int unsigned SEC_CYCLES = ccrb_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Device pins and charger status
  input wire logic adapter_present_i,
  input wire logic charge_pin_n_i,
  input wire logic dynamic_power_management_i,
  input wire logic charge_pin_function_en_i,
  input wire logic [7:0] charge_current_pin_setting_i,
  // Configuration to the charger
  output ccrb_pkg::ccrb_cfg_s cfg_o,
  output logic [7:0] termination_current_threshold_o,
  output logic charging_active_o,
  output logic safety_tick_o,
  output logic watchdog_expired_o
);
  import ccrb_pkg::*;

  typedef struct packed {
    ccrb_regs_s regs;
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic ad_s1, ad_s2, ad_s3;
    logic ce_s1, ce_s2;
    ccrb_i2c_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic [31:0] sec_div;
    logic [7:0] wd_sec;
    logic half_tog;
    logic safety_tick;
    logic wd_expired;
    logic [7:0] term_eff;
    logic chg_active;
  } ccrb_state_s;

  localparam ccrb_regs_s REGS_RST = '{term_code: RST_TERM_CODE, precharge_phase: RST_PRECHARGE_PHASE,
                                      timer: RST_TIMER, cv: RST_CV, chg: RST_CHG};

  ccrb_state_s q, d;

  function automatic logic [7:0] rd_byte(input ccrb_regs_s r, input logic [7:0] a);
    case (a)
      OFS_TERM_LO: rd_byte = {r.term_code[5:0], 2'b00};
      OFS_TERM_HI: rd_byte = {6'h00, r.term_code[7:6]};
      OFS_PRECHARGE_PHASE: rd_byte = r.precharge_phase;
      OFS_TIMER: rd_byte = r.timer;
      OFS_CV: rd_byte = r.cv;
      OFS_CHG: rd_byte = r.chg;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'b01: wd_limit = WD_PERIOD_1_S;
      2'b10: wd_limit = WD_PERIOD_2_S;
      default: wd_limit = WD_PERIOD_3_S;
    endcase
  endfunction

  always_comb begin
    logic scl_rise, scl_fall, start, stop, sec_tick, plug, wr_en;
    logic [7:0] code, nxt;
    d = q;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    sec_tick = 1'b0;
    plug = 1'b0;
    wr_en = 1'b0;
    code = q.regs.term_code;
    nxt = 8'h00;
    // Synchronisers
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.ad_s1 = adapter_present_i;
    d.ad_s2 = q.ad_s1;
    d.ad_s3 = q.ad_s2;
    d.ce_s1 = charge_pin_n_i;
    d.ce_s2 = q.ce_s1;
    scl_rise = q.scl_s2 & ~q.scl_s3;
    scl_fall = ~q.scl_s2 & q.scl_s3;
    start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    stop = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    plug = q.ad_s2 & ~q.ad_s3;
    d.safety_tick = 1'b0;
    d.wd_expired = 1'b0;

    // One-second divider and safety timer rate
    sec_tick = (q.sec_div == SEC_CYCLES - 1);
    d.sec_div = sec_tick ? 32'h0 : q.sec_div + 32'h1;
    if (sec_tick) begin
      d.half_tog = ~q.half_tog;
      if (q.regs.timer[TMR_HALF_RATE_BIT] && dynamic_power_management_i) begin
        d.safety_tick = q.half_tog;
      end else begin
        d.safety_tick = 1'b1;
      end
    end

    // Host watchdog
    if (q.regs.timer[5:4] == 2'b00) begin
      d.wd_sec = 8'h00;
    end else if (q.regs.chg[CHG_RESTART_BIT]) begin
      d.wd_sec = 8'h00;
    end else if (sec_tick) begin
      if (q.wd_sec + 8'h01 >= wd_limit(q.regs.timer[5:4])) begin
        d.wd_sec = 8'h00;
        d.wd_expired = 1'b1;
      end else begin
        d.wd_sec = q.wd_sec + 8'h01;
      end
    end
    d.regs.chg[CHG_RESTART_BIT] = 1'b0;
    if (d.wd_expired) begin
      d.regs.chg[CHG_LOAD_BIT] = 1'b0;
      d.regs.chg[CHG_HIZ_BIT] = 1'b0;
      d.regs.timer[TMR_SAFETY_EN_BIT] = 1'b1;
      d.regs.cv = RST_CV;
      d.regs.chg[CHG_ENABLE_BIT] = q.regs.chg[CHG_EXPIRY_VAL_BIT];
    end
    if (plug) begin
      d.regs.chg[CHG_HIZ_BIT] = 1'b0;
    end

    // I2C target; host writes are applied after hardware clears so a set wins
    if (start) begin
      d.st = I2C_ADDR;
      d.bit_cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st = I2C_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          d.shift = {q.shift[6:0], q.sda_s2};
          d.bit_cnt = q.bit_cnt + 4'h1;
        end
        I2C_RACK: begin
          if (q.sda_s2) begin
            d.st = I2C_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (q.st)
        I2C_ADDR: begin
          if (q.bit_cnt == 4'h8) begin
            if (q.shift[7:1] == DEV_ADDR) begin
              d.sda_oe = 1'b1;
              d.rw = q.shift[0];
              d.st = I2C_ADDR_ACK;
            end else begin
              d.st = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK, I2C_RACK: begin
          d.bit_cnt = 4'h0;
          if (q.st == I2C_RACK || q.rw) begin
            nxt = rd_byte(q.regs, q.ptr);
            d.shift = nxt;
            d.sda_oe = ~nxt[7];
            d.st = I2C_RDATA;
          end else begin
            d.sda_oe = 1'b0;
            d.st = I2C_PTR;
          end
        end
        I2C_PTR: begin
          if (q.bit_cnt == 4'h8) begin
            d.ptr = q.shift;
            d.sda_oe = 1'b1;
            d.st = I2C_PTR_ACK;
          end
        end
        I2C_PTR_ACK, I2C_WACK: begin
          d.sda_oe = 1'b0;
          d.bit_cnt = 4'h0;
          d.st = I2C_WDATA;
        end
        I2C_WDATA: begin
          if (q.bit_cnt == 4'h8) begin
            wr_en = 1'b1;
            d.ptr = q.ptr + 8'h01;
            d.sda_oe = 1'b1;
            d.st = I2C_WACK;
          end
        end
        I2C_RDATA: begin
          if (q.bit_cnt == 4'h7) begin
            d.sda_oe = 1'b0;
            d.ptr = q.ptr + 8'h01;
            d.st = I2C_RACK;
          end else begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            d.shift = {q.shift[6:0], 1'b0};
            d.sda_oe = ~q.shift[6];
          end
        end
        default: ;
      endcase
    end

    // Register writes
    if (wr_en) begin
      case (q.ptr)
        OFS_TERM_LO, OFS_TERM_HI: begin
          if (q.ptr == OFS_TERM_LO) begin
            code = {q.regs.term_code[7:6], q.shift[7:2]};
          end else begin
            code = {q.shift[1:0], q.regs.term_code[5:0]};
          end
          if (code < TERM_CODE_MIN) begin
            code = TERM_CODE_MIN;
          end else if (code > TERM_CODE_MAX) begin
            code = TERM_CODE_MAX;
          end
          d.regs.term_code = code;
        end
        OFS_PRECHARGE_PHASE: d.regs.precharge_phase = q.shift & WMASK_LOW4;
        OFS_TIMER: d.regs.timer = q.shift;
        OFS_CV: d.regs.cv = q.shift & WMASK_LOW4;
        OFS_CHG: d.regs.chg = q.shift;
        OFS_PATH: begin
          if (q.shift[PATH_REG_RESET_BIT]) begin
            d.regs = REGS_RST;
            d.wd_sec = 8'h00;
          end
        end
        default: ;
      endcase
    end

    // Effective outputs
    if (charge_pin_function_en_i && charge_current_pin_setting_i < q.regs.term_code) begin
      d.term_eff = charge_current_pin_setting_i;
    end else begin
      d.term_eff = q.regs.term_code;
    end
    d.chg_active = q.regs.chg[CHG_ENABLE_BIT] &
                   (q.regs.chg[CHG_PIN_IGNORE_BIT] | ~q.ce_s2);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.regs <= REGS_RST;
      q.st <= I2C_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.ce_s1 <= 1'b1;
      q.ce_s2 <= 1'b1;
      q.term_eff <= RST_TERM_CODE;
    end else begin
      q <= d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign termination_current_threshold_o = q.term_eff;
  assign charging_active_o = q.chg_active;
  assign safety_tick_o = q.safety_tick;
  assign watchdog_expired_o = q.wd_expired;
  always_comb begin
    cfg_o.termination_enable = q.regs.precharge_phase[3];
    cfg_o.fastcharge_entry_threshold = q.regs.precharge_phase[2:1];
    cfg_o.precharge_enable = q.regs.precharge_phase[0];
    cfg_o.topoff_timer_select = q.regs.timer[7:6];
    cfg_o.watchdog_select = q.regs.timer[5:4];
    cfg_o.safety_timer_enable = q.regs.timer[TMR_SAFETY_EN_BIT];
    cfg_o.safety_timer_select = q.regs.timer[2:1];
    cfg_o.safety_timer_half_rate = q.regs.timer[TMR_HALF_RATE_BIT];
    cfg_o.constant_voltage_timer = q.regs.cv[3:0];
    cfg_o.auto_recharge_threshold = q.regs.chg[7:6];
    cfg_o.high_impedance_enable = q.regs.chg[CHG_HIZ_BIT];
    cfg_o.battery_load_enable = q.regs.chg[CHG_LOAD_BIT];
    cfg_o.charging_enable = q.regs.chg[CHG_ENABLE_BIT];
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_term_code_range: assert property (
    q.regs.term_code >= TERM_CODE_MIN && q.regs.term_code <= TERM_CODE_MAX)
    else $error("termination code outside clamp range");
  a_restart_self_clear: assert property (
    q.regs.chg[CHG_RESTART_BIT] |=> !q.regs.chg[CHG_RESTART_BIT] && q.wd_sec == 8'h00)
    else $error("watchdog restart bit did not clear or restart");
  a_expiry_defaults: assert property (
    q.wd_expired |-> !q.regs.chg[CHG_LOAD_BIT] && !q.regs.chg[CHG_HIZ_BIT]
                     && q.regs.timer[TMR_SAFETY_EN_BIT] && q.regs.cv == RST_CV)
    else $error("fields not restored on watchdog expiry");
  a_expiry_charge_val: assert property (
    q.wd_expired |-> q.regs.chg[CHG_ENABLE_BIT] == $past(q.regs.chg[CHG_EXPIRY_VAL_BIT]))
    else $error("charge enable not loaded from expiry value");
  a_pin_ignore_gate: assert property (
    ##1 charging_active_o == $past(q.regs.chg[CHG_ENABLE_BIT]
        & (q.regs.chg[CHG_PIN_IGNORE_BIT] | ~q.ce_s2)))
    else $error("charge pin gating wrong");
  a_term_lower_pick: assert property (
    ##1 termination_current_threshold_o <= $past(q.regs.term_code))
    else $error("effective termination above programmed code");
  a_plug_clears_hiz: assert property (
    q.ad_s2 && !q.ad_s3 && !(q.st == I2C_WDATA) |=> !q.regs.chg[CHG_HIZ_BIT])
    else $error("adapter plug-in did not clear high impedance");
  a_wd_disabled_quiet: assert property (
    q.wd_expired |-> $past(q.regs.timer[5:4]) != 2'b00)
    else $error("watchdog expired while disabled");
  a_half_rate_tick: assert property (
    safety_tick_o && $past(q.regs.timer[TMR_HALF_RATE_BIT])
    && $past(dynamic_power_management_i) |-> !q.half_tog)
    else $error("safety tick at full rate during DYNAMIC_POWER_MANAGEMENT");
endmodule
